// ---- hdl/rcd_ref_clock_divider.sv ----
// Notes on behaviour
// - oscillator runs while chip enable is high and bypass control is low
// - oscillator runs by default after power-up
// - chip enable low stops the oscillator
// - bypass high selects external cmos reference input
// - divided output has equal high and low
// - only even ratios two through thirty
// - ratio from top four bits of reference word
// - power-up ratio is divide by sixteen
// - output buffer enabled only when enable bit set
// - buffer enable bit is one after power-up
// - chip enable low restores all defaults
// - word shifted msb first, latched on strobe
module rcd_ref_clock_divider (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clkEn,
  input  wire logic chipEnable,
  input  wire logic crystal_osc_bypass,
  input  wire logic xtalOscIn,
  input  wire logic ref_input_pin,
  input  wire logic serialClk,
  input  wire logic serialData,
  input  wire logic load_strobe,
  output logic      oscRunning,
  output logic      refClk,
  output logic      divided_ref_output,
  output logic      bufferEnabled,
  output logic [3:0] divField
);
  localparam int W = rcd_pkg::HALF_CNT_W;

  logic [rcd_pkg::REF_WORD_W-1:0] shiftWord;
  logic                           sclkPrev;
  logic                           strobePrev;
  logic                           output_buffer_enable_bit;
  logic                           srcPrev;
  logic                           srcEdge;
  logic                           divPhase;
  logic                           halfDone;
  logic [3:0]                     activeField;
  logic [1:0]                     latch_select;
  logic [4:0]                     halfEdges;

  // field to ratio, always even since the lsb is forced to zero
  function automatic logic [4:0] ratio_of(input logic [3:0] f);
    ratio_of = {f, 1'b0};
  endfunction : ratio_of

  // oscillator runs with chip enabled and bypass low; bypass uses pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oscRunning <= 1'b1;
      refClk     <= 1'b0;
    end else if (clkEn) begin
      oscRunning <= chipEnable && !crystal_osc_bypass;
      if (!chipEnable) begin
        refClk <= 1'b0;
      end else if (crystal_osc_bypass) begin
        refClk <= ref_input_pin;
      end else begin
        refClk <= xtalOscIn;
      end
    end
  end

  // serial shift, msb first on rising serial clock edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftWord <= '0;
      sclkPrev  <= 1'b0;
    end else if (clkEn) begin
      sclkPrev <= serialClk;
      if (!chipEnable) begin
        shiftWord <= '0;
      end else if (serialClk && !sclkPrev) begin
        shiftWord <= {shiftWord[rcd_pkg::REF_WORD_W-2:0],
                      serialData};
      end
    end
  end

  assign latch_select = shiftWord[1:0];

  // latch on rising strobe; chip enable low wipes to defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobePrev               <= 1'b0;
      divField                 <= rcd_pkg::DIV_FIELD_RESET;
      output_buffer_enable_bit <= rcd_pkg::BUF_EN_RESET;
    end else if (clkEn) begin
      strobePrev <= load_strobe;
      if (!chipEnable) begin
        divField                 <= rcd_pkg::DIV_FIELD_RESET;
        output_buffer_enable_bit <= rcd_pkg::BUF_EN_RESET;
      end else if (load_strobe && !strobePrev) begin
        case (latch_select)
          rcd_pkg::SEL_REF: begin
            // a zero field would mean ratio 0, clamp to 2
            divField <= (shiftWord[rcd_pkg::DIV_FIELD_MSB -: 4] == 4'h0)
                        ? rcd_pkg::DIV_FIELD_MIN
                        : shiftWord[rcd_pkg::DIV_FIELD_MSB -: 4];
          end
          rcd_pkg::SEL_FUNC: begin
            output_buffer_enable_bit <=
              shiftWord[rcd_pkg::BUF_EN_POS];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // rising edge of the selected reference drives the divider
  assign srcEdge = refClk && !srcPrev;

  // field changes only take effect at a half boundary, no runt halves
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      srcPrev     <= 1'b0;
      activeField <= rcd_pkg::DIV_FIELD_RESET;
    end else if (clkEn) begin
      srcPrev <= refClk;
      if (!chipEnable || (halfDone && srcEdge)) begin
        activeField <= divField;
      end
    end
  end

  rcd_half_counter #(
    .W (W)
  ) u_half (
    .clk      (clk),
    .reset_n  (reset_n),
    .clkEn    (clkEn && (srcEdge || !chipEnable)),
    .run      (chipEnable),
    .halfLen  (activeField),
    .halfDone (halfDone)
  );

  // equal halves of field source cycles each give a 50:50 output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divPhase <= 1'b0;
    end else if (clkEn) begin
      if (!chipEnable) begin
        divPhase <= 1'b0;
      end else if (srcEdge && halfDone) begin
        divPhase <= ~divPhase;
      end
    end
  end

  // gated output buffer, low when disabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divided_ref_output <= 1'b0;
      bufferEnabled      <= rcd_pkg::BUF_EN_RESET;
    end else if (clkEn) begin
      divided_ref_output <= divPhase && output_buffer_enable_bit;
      bufferEnabled      <= output_buffer_enable_bit;
    end
  end

  // shared sampling for the checks below; reset masks them all
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // source edges seen in the current half, counted apart from the half
  // counter so a wrong terminal compare there cannot hide
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halfEdges <= 5'h00;
    end else if (clkEn) begin
      if (!chipEnable || (srcEdge && halfDone)) begin
        halfEdges <= 5'h00;
      end else if (srcEdge) begin
        halfEdges <= halfEdges + 5'h01;
      end
    end
  end

  a_buf_gates_out: assert property (
    clkEn && !output_buffer_enable_bit |=> !divided_ref_output)
    else $error("output active with buffer disabled");
  a_ce_defaults: assert property (
    clkEn && !chipEnable |=> divField == rcd_pkg::DIV_FIELD_RESET
      && output_buffer_enable_bit)
    else $error("defaults not restored");
  a_field_nonzero: assert property (
    divField != 4'h0)
    else $error("zero divide field");
  a_even_ratio: assert property (
    clkEn && chipEnable && srcEdge && halfDone
    |-> ratio_of(4'(halfEdges + 5'h01)) >= ratio_of(rcd_pkg::DIV_FIELD_MIN)
      && ratio_of(4'(halfEdges + 5'h01)) <= ratio_of(rcd_pkg::DIV_FIELD_MAX))
    else $error("ratio outside two to thirty");
  a_half_len: assert property (
    clkEn && chipEnable && srcEdge && halfDone
    |-> halfEdges + 5'h01 == {1'b0, activeField})
    else $error("half period differs from field");
  a_osc_stop: assert property (
    clkEn && !chipEnable |=> !oscRunning && !refClk)
    else $error("oscillator runs with chip disabled");
  a_osc_run: assert property (
    clkEn && chipEnable && !crystal_osc_bypass |=> oscRunning)
    else $error("oscillator not running");
  a_div_held: assert property (
    clkEn && !chipEnable |=> !divPhase)
    else $error("divider not held");
  a_phase_stable: assert property (
    clkEn && chipEnable && !(srcEdge && halfDone) |=> $stable(divPhase))
    else $error("phase toggled off boundary");
  a_func_latch: assert property (
    clkEn && chipEnable && load_strobe && !strobePrev
      && latch_select == rcd_pkg::SEL_FUNC
    |=> output_buffer_enable_bit == $past(shiftWord[rcd_pkg::BUF_EN_POS]))
    else $error("function word not latched");
  a_en_freeze: assert property (
    !clkEn |=> $stable(divPhase) && $stable(divField)
      && $stable(divided_ref_output))
    else $error("state moved with clock enable low");

  c_out_toggles: cover property (@(posedge clk) divPhase ##1 !divPhase);
  c_ref_load: cover property (@(posedge clk) load_strobe && !strobePrev
    && latch_select == rcd_pkg::SEL_REF && chipEnable);
  c_bypass: cover property (@(posedge clk) chipEnable && crystal_osc_bypass);
  c_buf_off: cover property (@(posedge clk) !output_buffer_enable_bit
    && divPhase);
  c_frozen: cover property (@(posedge clk) !clkEn && chipEnable);
endmodule : rcd_ref_clock_divider

// ---- hdl/rcd_pkg.sv ----
package rcd_pkg;
  // divide field width and power-up value (ratio = 2 * field)
  localparam int          DIV_FIELD_W     = 4;
  localparam logic [3:0]  DIV_FIELD_RESET = 4'h8;
  localparam logic [3:0]  DIV_FIELD_MIN   = 4'h1;
  localparam logic [3:0]  DIV_FIELD_MAX   = 4'hF;
  // msb position of divide field inside the 24-bit reference word
  localparam int          REF_WORD_W      = 24;
  localparam int          DIV_FIELD_MSB   = 23;
  // buffer enable bit position in the function word and its reset
  localparam int          BUF_EN_POS      = 4;
  localparam logic        BUF_EN_RESET    = 1'b1;
  // latch select codes in the two lsbs
  localparam logic [1:0]  SEL_REF         = 2'h0;
  localparam logic [1:0]  SEL_FUNC        = 2'h3;
  // half-period counter width
  localparam int          HALF_CNT_W      = 4;
  localparam logic [3:0]  HALF_CNT_RESET  = 4'h0;
endpackage : rcd_pkg

// ---- hdl/rcd_half_counter.sv ----
// counts source edges for one half period of the divided clock
module rcd_half_counter #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clkEn,
  input  wire logic         run,
  input  wire logic [W-1:0] halfLen,
  output logic              halfDone
);
  logic [W-1:0] count;

  // terminal count reached when count equals half length minus one
  assign halfDone = run && (count == halfLen - W'(1));

  // cleared whenever not running so each restart begins a fresh half
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= W'(rcd_pkg::HALF_CNT_RESET);
    end else if (clkEn) begin
      if (!run || halfDone) begin
        count <= W'(rcd_pkg::HALF_CNT_RESET);
      end else begin
        count <= count + W'(1);
      end
    end
  end
endmodule : rcd_half_counter

// ---- tb/rcd_ref_model.sv ----
// crystal and external reference sources facing the divider
module rcd_ref_model #(
  parameter int XH = 4,
  parameter int EH = 3
) (
  input  wire logic clk,
  input  wire logic extSel,
  output logic      xtalWave,
  output logic      extWave
);
  timeunit 1ns;
  timeprecision 1ns;
  int xc = 0;
  int ec = 0;
  initial begin
    xtalWave = 1'b0;
    extWave  = 1'b0;
  end
  // crystal runs free; the device decides whether it is used
  always @(posedge clk) begin
    xc = (xc + 1) % XH;
    if (xc == 0) xtalWave <= ~xtalWave;
  end
  // cmos reference only when selected, else noise every cycle
  always @(posedge clk) begin
    ec = (ec + 1) % EH;
    if (!extSel) extWave <= ~extWave;
    else if (ec == 0) extWave <= ~extWave;
  end
endmodule : rcd_ref_model

// ---- tb/tb_rcd_ref_clock_divider.sv ----
module tb_rcd_ref_clock_divider;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int XH = 4;
  localparam int EH = 3;
  logic clk, reset_n, clkEn, chipEnable, bypass, xtal, ext;
  logic sClk, sData, strobe, oscRunning, refClk, outClk, bufEn;
  logic [3:0] divField;
  logic [7:0] expQ[$];
  int   n_errors = 0;
  int   compares = 0;
  int   len = 0;
  logic prevOut = 1'b0;
  int   f;
  logic hold;
  rcd_ref_model #(.XH(XH), .EH(EH)) src (.clk(clk), .extSel(bypass),
    .xtalWave(xtal), .extWave(ext));
  rcd_ref_clock_divider dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .chipEnable(chipEnable), .crystal_osc_bypass(bypass),
    .xtalOscIn(xtal), .ref_input_pin(ext), .serialClk(sClk),
    .serialData(sData), .load_strobe(strobe), .oscRunning(oscRunning),
    .refClk(refClk), .divided_ref_output(outClk),
    .bufferEnabled(bufEn), .divField(divField));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // msb first, serial clock held high two samples and low three per bit
  task automatic prog(input logic [23:0] w);
    @(posedge clk);
    for (int i = 23; i >= 0; i--) begin
      sData <= w[i];
      @(posedge clk) sClk <= 1'b1;
      repeat (2) @(posedge clk);
      sClk <= 1'b0;
      repeat (2) @(posedge clk);
    end
    strobe <= 1'b1;
    repeat (2) @(posedge clk);
    strobe <= 1'b0;
    repeat (4) @(negedge clk);
  endtask : prog
  // settle, then note both halves of one period and wait for them
  task automatic measure(input int h);
    repeat (300) @(posedge clk);
    expQ.push_back(8'(h));
    expQ.push_back(8'(h));
    for (int i = 0; i < 800 && expQ.size() > 0; i++) @(posedge clk);
    if (expQ.size() != 0) chk("edges", 8'h00, 8'h01);
    expQ.delete();
  endtask : measure
  // half-period monitor: each output edge retires one note while any are pending
  always @(posedge clk) begin
    if (outClk !== prevOut) begin
      if (expQ.size() > 0) chk("half", 8'(len), expQ.pop_front());
      len = 1;
    end else len++;
    prevOut = outClk;
  end
  initial begin
    #(100 * 30000);
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'hE72B));
    {reset_n, sClk, sData, strobe, bypass} = 5'h00;
    clkEn = 1'b1;
    chipEnable = 1'b1;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk("osc", {7'h00, oscRunning}, 8'h01);
    chk("field", {4'h0, divField}, 8'h08);
    chk("bufEn", {7'h00, bufEn}, 8'h01);
    measure(16 * XH);
    // clock enable low must freeze the divided output past a half
    @(posedge clk) clkEn <= 1'b0;
    repeat (2) @(negedge clk);
    hold = outClk;
    repeat (100) @(negedge clk);
    chk("frozen", {7'h00, outClk}, {7'h00, hold});
    @(posedge clk) clkEn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      f = (k < 3) ? 15 - 7 * k - (k / 2) : $urandom_range(15, 1);
      prog({4'(f), 18'h0, rcd_pkg::SEL_REF});
      if (f == 0) f = 1;
      chk("field", {4'h0, divField}, 8'(f));
      measure(f * 2 * XH);
    end
    prog({19'h0, 1'b0, 2'h0, rcd_pkg::SEL_FUNC});
    chk("bufEn", {7'h00, bufEn}, 8'h00);
    repeat (300) @(negedge clk);
    chk("gated", {7'h00, outClk}, 8'h00);
    prog({19'h0, 1'b1, 2'h0, rcd_pkg::SEL_FUNC});
    chk("bufEn", {7'h00, bufEn}, 8'h01);
    @(posedge clk);
    bypass <= 1'b1;
    repeat (3) @(negedge clk);
    chk("osc", {7'h00, oscRunning}, 8'h00);
    measure(f * 2 * EH);
    // leave non-default settings behind so the wipe is visible
    prog({4'h3, 18'h00000, rcd_pkg::SEL_REF});
    chk("field", {4'h0, divField}, 8'h03);
    prog({4'h5, 18'h00000, 2'h1});
    chk("field", {4'h0, divField}, 8'h03);
    prog({19'h00000, 1'b0, 2'h0, rcd_pkg::SEL_FUNC});
    chk("bufEn", {7'h00, bufEn}, 8'h00);
    @(posedge clk);
    bypass <= 1'b0;
    chipEnable <= 1'b0;
    repeat (6) @(negedge clk);
    chk("osc", {7'h00, oscRunning}, 8'h00);
    chk("ref", {7'h00, refClk}, 8'h00);
    chk("field", {4'h0, divField}, 8'h08);
    chk("bufEn", {7'h00, bufEn}, 8'h01);
    chk("out", {7'h00, outClk}, 8'h00);
    @(posedge clk);
    chipEnable <= 1'b1;
    repeat (3) @(negedge clk);
    chk("field", {4'h0, divField}, 8'h08);
    chk("bufEn", {7'h00, bufEn}, 8'h01);
    measure(16 * XH);
    conclude();
  end
endmodule : tb_rcd_ref_clock_divider
